// File: qfp_consts.vh
// Purpose: Shared constants for the queue frame pointer register bank.
// Assumes: Register index times four gives the AHB byte address.
// Notes: Definitions only; included by bare name.
`ifndef QFP_CONSTS_VH
`define QFP_CONSTS_VH
// Register indices; byte address is index * 4
`define QFP_IDX_TXQ_CMD 8'h80
`define QFP_IDX_RXQ_CMD 8'h82
`define QFP_IDX_TX_PTR 8'h84
`define QFP_IDX_RX_PTR 8'h86
`define QFP_IDX_RX_DTT 8'h8C
`define QFP_IDX_IEN 8'h90
`define QFP_IDX_IST 8'h92
`define QFP_IDX_ICLR 8'h94
`define QFP_IDX_DATA 8'hC0
// Field positions
`define QFP_BIT_AUTOINC 14
`define QFP_BIT_WST 12
`define QFP_BIT_EMS 11
`define QFP_BIT_DTT_STS 12
`define QFP_BIT_DTT_EN 7
`define QFP_BIT_SDA 3
`define QFP_BIT_MANUAL_ENQUEUE_TX 0
`define QFP_BIT_IRQ_RX 13
`define QFP_BIT_IRQ_TX 14
`define QFP_PTR_W 11
// Reset values and limits
`define QFP_PTR_RST 11'h000
`define QFP_DTT_RST 16'h0000
`define QFP_DTT_MAX 16'hCFFF
// Timing: one threshold unit in cycles of the core clock
`define QFP_TICK_US 1
`define QFP_NS_PER_US 1000
`define QFP_CLK_NS 4
`define QFP_CYC_PER_US ((`QFP_TICK_US * `QFP_NS_PER_US) / `QFP_CLK_NS)
`endif

// File: qfp_dur.v
// Purpose: Receive duration timer in microsecond units.
// Assumes: run is a same-clock level, high while frames wait.
// Notes: Count saturates so it never wraps below the threshold.
`timescale 1ns/1ps
`include "qfp_consts.vh"
module qfp_dur #(
  parameter CYC = `QFP_CYC_PER_US
) (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Control
  input wire run,
  input wire enable,
  input wire [15:0] thresh,
  // One-cycle pulse when the threshold is first exceeded
  output wire hit
);
  reg [15:0] div_ff; // Cycle divider
  reg [15:0] us_ff; // Elapsed microseconds
  reg over_ff; // Previous over state
  wire tick; // One-microsecond enable
  wire over; // Elapsed above threshold
  assign tick = (div_ff == CYC - 1);
  assign over = run && (us_ff > thresh);
  // Divider and counter clear when the buffer drains
  always @(posedge clock) begin
    if (!rst_n || !run) begin
      div_ff <= 16'h0000;
      us_ff <= 16'h0000;
    end else begin
      div_ff <= tick ? 16'h0000 : div_ff + 16'h0001;
      if (tick && us_ff != 16'hFFFF) begin
        us_ff <= us_ff + 16'h0001;
      end
    end
  end
  // Edge memory so one crossing gives one event
  always @(posedge clock) begin
    if (!rst_n) begin
      over_ff <= 1'b0;
    end else begin
      over_ff <= over;
    end
  end
  assign hit = enable && over && !over_ff;
endmodule // qfp_dur

// File: qfp_ptr.v
// Purpose: One frame buffer pointer with load and auto-increment.
// Assumes: Software load beats hardware load beats increment.
// Notes: Pointer wraps at its width.
`timescale 1ns/1ps
`include "qfp_consts.vh"
module qfp_ptr #(
  parameter W = `QFP_PTR_W
) (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Load requests
  input wire sw_load,
  input wire [W-1:0] sw_val,
  input wire hw_load,
  input wire [W-1:0] hw_val,
  // Increment request with AHB size code
  input wire inc,
  input wire [1:0] inc_size,
  // Pointer value
  output wire [W-1:0] ptr
);
  reg [W-1:0] ptr_ff; // Current pointer
  reg [W-1:0] nxt_ptr; // Next pointer
  wire [W-1:0] step; // Byte count of the access
  // Size code 0/1/2 gives step 1/2/4
  assign step = {{(W-3){1'b0}}, 3'h1} << inc_size;
  // Next value, software first
  always @* begin
    nxt_ptr = ptr_ff;
    if (sw_load) begin
      nxt_ptr = sw_val;
    end else if (hw_load) begin
      nxt_ptr = hw_val;
    end else if (inc) begin
      nxt_ptr = ptr_ff + step;
    end
  end
  // Pointer register
  always @(posedge clock) begin
    if (!rst_n) begin
      ptr_ff <= `QFP_PTR_RST;
    end else begin
      ptr_ff <= nxt_ptr;
    end
  end
  assign ptr = ptr_ff;
endmodule // qfp_ptr

// File: qfp_queue_model.sv
// Purpose: Queue and frame buffer model beside the register bank.
// Assumes: Read data must be valid in the read address phase.
// Notes: Data word carries its own address for easy checking.
`timescale 1ns/1ps
module qfp_queue_model #(
  parameter DLY = 20,
  parameter [10:0] NEXT = 11'h123
) (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Transmit queue
  input wire tx_enqueue,
  output reg tx_done,
  output wire [10:0] tx_next_free,
  // Receive buffer
  input wire [10:0] rx_buf_addr,
  input wire rx_buf_re,
  output wire [31:0] rx_buf_rdata
);
  integer cnt; // Cycles left until the frame is sent
  wire [31:0] word = {16'hA5A5, 5'h00, rx_buf_addr};
  assign tx_next_free = NEXT;
  // Outside a read the lines show the inverse so stale data never matches
  assign rx_buf_rdata = rx_buf_re ? word : ~word;
  // Frame is sent DLY cycles after it was queued
  always @(posedge clock) begin
    if (!rst_n) begin
      cnt <= 0;
      tx_done <= 1'b0;
    end else begin
      tx_done <= (cnt == 1);
      if (tx_enqueue)
        cnt <= DLY;
      else if (cnt != 0)
        cnt <= cnt - 1;
    end
  end
endmodule // qfp_queue_model

// File: qfp_regs.v
// Purpose: AHB-Lite register bank for TX/RX frame pointers and RX timer.
// Assumes: Zero wait states; single whole-transfer master.
// Notes: Frame buffers sit outside; this block only steers pointers.
`timescale 1ns/1ps
`include "qfp_consts.vh"
module qfp_regs (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  // TX frame buffer write port
  output wire [10:0] tx_buf_addr,
  output wire [31:0] tx_buf_wdata,
  output wire [1:0] tx_buf_size,
  output wire tx_buf_we,
  // RX frame buffer read port
  output wire [10:0] rx_buf_addr,
  output wire [1:0] rx_buf_size,
  output wire rx_buf_re,
  input wire [31:0] rx_buf_rdata,
  // Transmit queue handshake
  output wire tx_enqueue,
  input wire tx_done,
  input wire [10:0] tx_next_free,
  // Receive queue state
  input wire rx_nonempty,
  // Endian strap pin
  input wire endian_strap,
  // Configuration and status outputs
  output wire endian_big,
  output wire write_sample_sel,
  output wire dma_active,
  output wire irq
);

  // Register decode: exact word match, upper address bits zero
  function is_reg;
    input [31:0] a;
    input [7:0] idx;
    begin
      is_reg = (a[31:10] == 22'h000000) && (a[9:2] == idx) && (a[1:0] == 2'h0);
    end
  endfunction

  // Bus phase state
  reg dp_valid_ff; // Data phase pending
  reg dp_write_ff; // Data phase is a write
  reg [31:0] dp_addr_ff; // Latched address
  reg [1:0] dp_size_ff; // Latched size code
  reg [31:0] hrdata_ff; // Read data for the data phase

  // Software-visible control state
  reg tx_autoinc_ff; // TX pointer auto-increment
  reg rx_autoinc_ff; // RX pointer auto-increment
  reg wst_ff; // Write sample time select
  reg ems_ff; // Software endian choice
  reg [15:0] dtt_ff; // Duration threshold
  reg dtt_en_ff; // Duration threshold enable
  reg dtt_sts_ff; // Duration caused the RX interrupt
  reg sda_ff; // Start DMA access
  reg manual_enqueue_tx_ff; // Manual enqueue in flight
  reg [15:0] ien_ff; // Interrupt enables
  reg [15:0] ist_ff; // Sticky interrupt status

  // TX buffer write port flops
  reg [10:0] txb_addr_ff; // Write address
  reg [31:0] txb_wdata_ff; // Write data
  reg [1:0] txb_size_ff; // Write size
  reg txb_we_ff; // Write pulse

  // Strap synchroniser
  reg strap_s1_ff; // First stage, read only by second
  reg strap_s2_ff; // Stable strap level

  // Combinational helpers
  wire ap; // Address phase accepted
  wire rd_ap; // Read accepted
  wire wr; // Write in data phase
  wire blocked; // DMA holds the register file
  wire wr_txq; // Write to TX command
  wire wr_rxq; // Write to RX command
  wire wr_txp; // Write to TX pointer
  wire wr_rxp; // Write to RX pointer
  wire wr_dtt; // Write to threshold
  wire wr_ien; // Write to enables
  wire wr_iclr; // Write to status clear
  wire wr_data; // Write to frame data
  wire rd_data; // Read of frame data
  wire [10:0] tx_ptr; // TX pointer value
  wire [10:0] rx_ptr; // RX pointer value
  wire dur_hit; // Duration threshold event
  wire [15:0] ist_set; // Status set terms
  wire [15:0] ist_clr; // Status clear terms
  reg [31:0] rd_mux; // Read value selected by address

  // Zero wait states; every answer is OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  assign ap = hsel && hready && htrans[1];
  assign rd_ap = ap && !hwrite;
  assign wr = dp_valid_ff && dp_write_ff;

  // DMA keeps only the RX command and the data window open
  assign blocked = sda_ff;

  // Write strobes in the data phase
  assign wr_rxq = wr && is_reg(dp_addr_ff, `QFP_IDX_RXQ_CMD);
  assign wr_data = wr && is_reg(dp_addr_ff, `QFP_IDX_DATA);
  assign wr_txq = wr && !blocked && is_reg(dp_addr_ff, `QFP_IDX_TXQ_CMD);
  assign wr_txp = wr && !blocked && is_reg(dp_addr_ff, `QFP_IDX_TX_PTR);
  assign wr_rxp = wr && !blocked && is_reg(dp_addr_ff, `QFP_IDX_RX_PTR);
  assign wr_dtt = wr && !blocked && is_reg(dp_addr_ff, `QFP_IDX_RX_DTT);
  assign wr_ien = wr && !blocked && is_reg(dp_addr_ff, `QFP_IDX_IEN);
  assign wr_iclr = wr && !blocked && is_reg(dp_addr_ff, `QFP_IDX_ICLR);

  // Data reads use the pointer in the address phase
  assign rd_data = rd_ap && is_reg(haddr, `QFP_IDX_DATA);
  assign rx_buf_re = rd_data;
  assign rx_buf_addr = rx_ptr;
  assign rx_buf_size = hsize[1:0];

  // Address phase capture
  always @(posedge clock) begin
    if (!rst_n) begin
      dp_valid_ff <= 1'b0;
      dp_write_ff <= 1'b0;
      dp_addr_ff <= 32'h00000000;
      dp_size_ff <= 2'h0;
    end else if (hready) begin
      dp_valid_ff <= ap;
      dp_write_ff <= ap && hwrite;
      dp_addr_ff <= haddr;
      dp_size_ff <= hsize[1:0];
    end
  end

  // Read mux; write-only fields read as zero
  always @* begin
    rd_mux = 32'h00000000;
    if (is_reg(haddr, `QFP_IDX_RXQ_CMD)) begin
      rd_mux[`QFP_BIT_DTT_STS] = dtt_sts_ff;
      rd_mux[`QFP_BIT_DTT_EN] = dtt_en_ff;
    end else if (is_reg(haddr, `QFP_IDX_DATA)) begin
      rd_mux = rx_buf_rdata;
    end else if (blocked) begin
      rd_mux = 32'h00000000;
    end else if (is_reg(haddr, `QFP_IDX_TXQ_CMD)) begin
      rd_mux[`QFP_BIT_MANUAL_ENQUEUE_TX] = manual_enqueue_tx_ff;
    end else if (is_reg(haddr, `QFP_IDX_TX_PTR)) begin
      rd_mux[`QFP_BIT_AUTOINC] = tx_autoinc_ff;
      rd_mux[10:0] = tx_ptr;
    end else if (is_reg(haddr, `QFP_IDX_RX_PTR)) begin
      // Pointer field and endian bit are write-only
      rd_mux[`QFP_BIT_AUTOINC] = rx_autoinc_ff;
      rd_mux[`QFP_BIT_WST] = wst_ff;
    end else if (is_reg(haddr, `QFP_IDX_RX_DTT)) begin
      rd_mux[15:0] = dtt_ff;
    end else if (is_reg(haddr, `QFP_IDX_IEN)) begin
      rd_mux[15:0] = ien_ff;
    end else if (is_reg(haddr, `QFP_IDX_IST)) begin
      rd_mux[15:0] = ist_ff;
    end else begin
      rd_mux = 32'h00000000;
    end
  end

  // Read data held for the data phase
  always @(posedge clock) begin
    if (!rst_n) begin
      hrdata_ff <= 32'h00000000;
    end else if (rd_ap) begin
      hrdata_ff <= rd_mux;
    end
  end

  // TX pointer: software write, reload on done, advance on data write
  qfp_ptr #(
    .W(`QFP_PTR_W)
  ) u_tx_ptr (
    .clock(clock),
    .rst_n(rst_n),
    .sw_load(wr_txp),
    .sw_val(hwdata[10:0]),
    .hw_load(tx_done),
    .hw_val(tx_next_free),
    .inc(wr_data && tx_autoinc_ff),
    .inc_size(dp_size_ff),
    .ptr(tx_ptr)
  );

  // RX pointer: manual write, advance on data read
  qfp_ptr #(
    .W(`QFP_PTR_W)
  ) u_rx_ptr (
    .clock(clock),
    .rst_n(rst_n),
    .sw_load(wr_rxp),
    .sw_val(hwdata[10:0]),
    .hw_load(1'b0),
    .hw_val(`QFP_PTR_RST),
    .inc(rd_data && rx_autoinc_ff),
    .inc_size(hsize[1:0]),
    .ptr(rx_ptr)
  );

  // Duration timer on the receive queue occupancy
  qfp_dur #(
    .CYC(`QFP_CYC_PER_US)
  ) u_dur (
    .clock(clock),
    .rst_n(rst_n),
    .run(rx_nonempty),
    .enable(dtt_en_ff),
    .thresh(dtt_ff),
    .hit(dur_hit)
  );

  // Pointer control bits
  always @(posedge clock) begin
    if (!rst_n) begin
      tx_autoinc_ff <= 1'b0;
      rx_autoinc_ff <= 1'b0;
      wst_ff <= 1'b0;
      ems_ff <= 1'b0;
    end else begin
      if (wr_txp) begin
        tx_autoinc_ff <= hwdata[`QFP_BIT_AUTOINC];
      end
      if (wr_rxp) begin
        rx_autoinc_ff <= hwdata[`QFP_BIT_AUTOINC];
        wst_ff <= hwdata[`QFP_BIT_WST];
        ems_ff <= hwdata[`QFP_BIT_EMS];
      end
    end
  end

  // Threshold; values above the maximum are clamped
  always @(posedge clock) begin
    if (!rst_n) begin
      dtt_ff <= `QFP_DTT_RST;
    end else if (wr_dtt) begin
      if (hwdata[15:0] > `QFP_DTT_MAX) begin
        dtt_ff <= `QFP_DTT_MAX;
      end else begin
        dtt_ff <= hwdata[15:0];
      end
    end
  end

  // RX command register: enable and DMA gate
  always @(posedge clock) begin
    if (!rst_n) begin
      dtt_en_ff <= 1'b0;
      sda_ff <= 1'b0;
    end else if (wr_rxq) begin
      dtt_en_ff <= hwdata[`QFP_BIT_DTT_EN];
      sda_ff <= hwdata[`QFP_BIT_SDA];
    end
  end

  // Manual enqueue; a new write wins over a done in the same cycle
  always @(posedge clock) begin
    if (!rst_n) begin
      manual_enqueue_tx_ff <= 1'b0;
    end else if (wr_txq && hwdata[`QFP_BIT_MANUAL_ENQUEUE_TX]) begin
      manual_enqueue_tx_ff <= 1'b1;
    end else if (tx_done) begin
      manual_enqueue_tx_ff <= 1'b0;
    end
  end
  // Pulse when no frame is in flight or the last one ends this cycle; a write
  // that meets tx_done keeps the bit set, so it must also queue its frame
  assign tx_enqueue = wr_txq && hwdata[`QFP_BIT_MANUAL_ENQUEUE_TX] && (!manual_enqueue_tx_ff || tx_done);

  // Interrupt status: set wins over clear
  assign ist_set = ({15'h0000, dur_hit} << `QFP_BIT_IRQ_RX) |
                   ({15'h0000, tx_done} << `QFP_BIT_IRQ_TX);
  assign ist_clr = wr_iclr ? hwdata[15:0] : 16'h0000;
  always @(posedge clock) begin
    if (!rst_n) begin
      ist_ff <= 16'h0000;
      ien_ff <= 16'h0000;
    end else begin
      ist_ff <= (ist_ff & ~ist_clr) | ist_set;
      if (wr_ien) begin
        ien_ff <= hwdata[15:0];
      end
    end
  end

  // Cause flag follows the RX status bit lifetime
  always @(posedge clock) begin
    if (!rst_n) begin
      dtt_sts_ff <= 1'b0;
    end else if (dur_hit) begin
      dtt_sts_ff <= 1'b1;
    end else if (ist_clr[`QFP_BIT_IRQ_RX]) begin
      dtt_sts_ff <= 1'b0;
    end
  end

  assign irq = |(ist_ff & ien_ff);

  // TX buffer write port, one cycle after the data phase
  always @(posedge clock) begin
    if (!rst_n) begin
      txb_addr_ff <= `QFP_PTR_RST;
      txb_wdata_ff <= 32'h00000000;
      txb_size_ff <= 2'h0;
      txb_we_ff <= 1'b0;
    end else begin
      txb_we_ff <= wr_data;
      if (wr_data) begin
        txb_addr_ff <= tx_ptr;
        txb_wdata_ff <= hwdata;
        txb_size_ff <= dp_size_ff;
      end
    end
  end
  assign tx_buf_addr = txb_addr_ff;
  assign tx_buf_wdata = txb_wdata_ff;
  assign tx_buf_size = txb_size_ff;
  assign tx_buf_we = txb_we_ff;

  // Strap pin crosses in through two flops
  always @(posedge clock) begin
    if (!rst_n) begin
      strap_s1_ff <= 1'b0;
      strap_s2_ff <= 1'b0;
    end else begin
      strap_s1_ff <= endian_strap;
      strap_s2_ff <= strap_s1_ff;
    end
  end

  // Software choice counts only while the strap is low
  assign endian_big = strap_s2_ff ? 1'b1 : ems_ff;
  assign write_sample_sel = wst_ff;
  assign dma_active = sda_ff;

endmodule // qfp_regs

// File: qfp_regs_chk.sv
// Purpose: Port checks for the queue frame pointer register bank.
// Assumes: Byte address is register index times four.
// Notes: Bound to qfp_regs below.
`timescale 1ns/1ps
module qfp_regs_chk (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hwdata,
  input wire [31:0] hrdata,
  // Buffers and queue
  input wire tx_buf_we,
  input wire [10:0] rx_buf_addr,
  input wire [1:0] rx_buf_size,
  input wire rx_buf_re,
  input wire tx_enqueue,
  // Configuration
  input wire endian_strap,
  input wire endian_big,
  input wire write_sample_sel,
  input wire dma_active
);
  reg wp_ff; // Write data phase in progress
  reg [11:0] wa_ff; // Byte address of that write
  reg rai_ff; // RX auto-increment as last written
  wire acc = hsel & hready & htrans[1];
  wire wr_rx = wp_ff && wa_ff == 12'h218;
  wire wr_dat = wp_ff && wa_ff == 12'h300;
  wire wd3 = hwdata[3];
  wire wd12 = hwdata[12];
  // Track the address phase so data-phase effects can be tied to it
  always @(posedge clock) begin
    if (!rst_n) begin
      wp_ff <= 1'b0;
      wa_ff <= 12'h000;
      rai_ff <= 1'b0;
    end else begin
      wp_ff <= acc & hwrite;
      wa_ff <= haddr[11:0];
      // Blocked writes during DMA leave the mode unchanged
      if (wr_rx && !dma_active) begin
        rai_ff <= hwdata[14];
      end
    end
  end
  AST_RD_STROBE: assert property (@(posedge clock) disable iff (!rst_n)
    rx_buf_re == (acc && !hwrite && haddr == 32'h300)) else $error("read strobe wrong");
  AST_RX_STEP: assert property (@(posedge clock) disable iff (!rst_n)
    rx_buf_re && rai_ff |=> rx_buf_addr == $past(rx_buf_addr) + (11'h001 << $past(rx_buf_size)))
    else $error("rx pointer step wrong");
  AST_RX_MANUAL: assert property (@(posedge clock) disable iff (!rst_n)
    rx_buf_re && !rai_ff |=> $stable(rx_buf_addr)) else $error("rx pointer moved on manual");
  AST_RX_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    !rx_buf_re && !wr_rx |=> $stable(rx_buf_addr)) else $error("rx pointer moved");
  AST_TX_WE: assert property (@(posedge clock) disable iff (!rst_n)
    tx_buf_we == $past(wr_dat)) else $error("tx buffer write mistimed");
  AST_ENQ: assert property (@(posedge clock) disable iff (!rst_n)
    tx_enqueue |-> wp_ff && wa_ff == 12'h200 && hwdata[0]) else $error("stray enqueue");
  AST_WSS: assert property (@(posedge clock) disable iff (!rst_n)
    wr_rx && !dma_active |=> write_sample_sel == $past(wd12)) else $error("sample select");
  AST_DMA: assert property (@(posedge clock) disable iff (!rst_n)
    wp_ff && wa_ff == 12'h208 |=> dma_active == $past(wd3)) else $error("dma flag wrong");
  AST_BLOCK: assert property (@(posedge clock) disable iff (!rst_n)
    dma_active && acc && !hwrite && haddr == 32'h210 |=> hrdata == 32'h0)
    else $error("register readable during dma");
  AST_STRAP: assert property (@(posedge clock) disable iff (!rst_n)
    $past(endian_strap, 2) && $past(rst_n) && $past(rst_n, 2) |-> endian_big)
    else $error("strap not forcing big endian");
endmodule // qfp_regs_chk
bind qfp_regs qfp_regs_chk u_chk (.clock(clock), .rst_n(rst_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .hrdata(hrdata), .tx_buf_we(tx_buf_we), .rx_buf_addr(rx_buf_addr),
  .rx_buf_size(rx_buf_size), .rx_buf_re(rx_buf_re), .tx_enqueue(tx_enqueue),
  .endian_strap(endian_strap), .endian_big(endian_big),
  .write_sample_sel(write_sample_sel), .dma_active(dma_active));

// File: tb.sv
// Purpose: Self-checking bench for the queue frame pointer register bank.
// Assumes: Zero-wait AHB slave, 250 cycles per microsecond.
// Notes: Register byte address is index times four.
`timescale 1ns/1ps
module tb;
  reg clock, rst_n, hsel, hwrite, rx_nonempty, endian_strap;
  reg [31:0] haddr, hwdata, rd;
  reg [1:0] htrans;
  reg [2:0] hsize;
  reg [10:0] p;
  wire hreadyout, hresp, tx_buf_we, rx_buf_re, tx_enqueue, tx_done;
  wire hready; // The lone slave's ready is the bus ready
  assign hready = hreadyout;
  wire endian_big, write_sample_sel, dma_active, irq;
  wire [31:0] hrdata, tx_buf_wdata, rx_buf_rdata;
  wire [10:0] tx_buf_addr, rx_buf_addr, tx_next_free;
  wire [1:0] tx_buf_size, rx_buf_size;
  integer n_mismatch, tests_run, i;
  qfp_regs uut (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tx_buf_addr(tx_buf_addr),
    .tx_buf_wdata(tx_buf_wdata), .tx_buf_size(tx_buf_size), .tx_buf_we(tx_buf_we),
    .rx_buf_addr(rx_buf_addr), .rx_buf_size(rx_buf_size), .rx_buf_re(rx_buf_re),
    .rx_buf_rdata(rx_buf_rdata), .tx_enqueue(tx_enqueue), .tx_done(tx_done),
    .tx_next_free(tx_next_free), .rx_nonempty(rx_nonempty), .endian_strap(endian_strap),
    .endian_big(endian_big), .write_sample_sel(write_sample_sel),
    .dma_active(dma_active), .irq(irq));
  qfp_queue_model u_q (.clock(clock), .rst_n(rst_n), .tx_enqueue(tx_enqueue),
    .tx_done(tx_done), .tx_next_free(tx_next_free), .rx_buf_addr(rx_buf_addr),
    .rx_buf_re(rx_buf_re), .rx_buf_rdata(rx_buf_rdata));
  // One AHB single transfer; read data lands in rd
  task bus(input [31:0] a, input w, input [2:0] s, input [31:0] d);
    begin
      @(posedge clock);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= s;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      rd = hrdata;
    end
  endtask
  // Compare one value
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Read a register and compare
  task rdchk(input [31:0] a, input [2:0] s, input [31:0] exp);
    begin
      bus(a, 1'b0, s, 32'h0);
      chk(rd, exp);
    end
  endtask
  // Verdict
  task close_out;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch = n_mismatch + 1;
    close_out;
  end
  initial begin
    {rst_n, hsel, hwrite, rx_nonempty, endian_strap} = 5'h00;
    {haddr, hwdata, htrans, hsize} = 69'h0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    rdchk(32'h210, 3'h2, 32'h0);
    rdchk(32'h230, 3'h2, 32'h0);
    // TX auto-increment by byte, half word and word
    bus(32'h210, 1'b1, 3'h2, 32'h4010);
    p = 11'h010;
    for (i = 0; i < 3; i = i + 1) begin
      bus(32'h300, 1'b1, i[2:0], 32'h5A000000 | i);
      #1 chk({tx_buf_we, tx_buf_size, tx_buf_addr}, {1'b1, i[1:0], p});
      chk(tx_buf_wdata, 32'h5A000000 | i);
      p = p + (11'h001 << i);
    end
    rdchk(32'h210, 3'h2, 32'h4000 | {21'h0, p});
    bus(32'h210, 1'b1, 3'h2, 32'h0020);
    bus(32'h300, 1'b1, 3'h2, 32'h0);
    rdchk(32'h210, 3'h2, 32'h0020);
    // RX auto-increment; write-only fields read zero
    bus(32'h218, 1'b1, 3'h2, 32'h5805);
    rdchk(32'h218, 3'h2, 32'h5000);
    #1 chk({31'h0, write_sample_sel}, 32'h1);
    chk({31'h0, endian_big}, 32'h1);
    p = 11'h005;
    for (i = 0; i < 3; i = i + 1) begin
      rdchk(32'h300, i[2:0], 32'hA5A50000 | {21'h0, p});
      p = p + (11'h001 << i);
    end
    bus(32'h218, 1'b1, 3'h2, 32'h0);
    rdchk(32'h300, 3'h2, 32'hA5A50000);
    rdchk(32'h300, 3'h2, 32'hA5A50000);
    #1 chk({31'h0, endian_big}, 32'h0);
    @(posedge clock) endian_strap <= 1'b1;
    repeat (3) @(posedge clock);
    #1 chk({31'h0, endian_big}, 32'h1);
    @(posedge clock) endian_strap <= 1'b0;
    // DMA blocks other registers
    bus(32'h230, 1'b1, 3'h2, 32'h0007);
    bus(32'h208, 1'b1, 3'h2, 32'h0008);
    rdchk(32'h210, 3'h2, 32'h0);
    bus(32'h230, 1'b1, 3'h2, 32'h0001);
    bus(32'h208, 1'b1, 3'h2, 32'h0000);
    rdchk(32'h230, 3'h2, 32'h0007);
    // Duration threshold raises the receive interrupt after three microseconds
    bus(32'h230, 1'b1, 3'h2, 32'hFFFF);
    rdchk(32'h230, 3'h2, 32'hCFFF);
    bus(32'h230, 1'b1, 3'h2, 32'h0002);
    bus(32'h240, 1'b1, 3'h2, 32'h6000);
    bus(32'h208, 1'b1, 3'h2, 32'h0080);
    @(posedge clock) rx_nonempty <= 1'b1;
    repeat (700) @(posedge clock);
    #1 chk({31'h0, irq}, 32'h0);
    for (i = 0; i < 200 && irq !== 1'b1; i = i + 1) @(posedge clock);
    #1 chk({31'h0, irq}, 32'h1);
    rdchk(32'h248, 3'h2, 32'h2000);
    rdchk(32'h208, 3'h2, 32'h1080);
    rdchk(32'h248, 3'h2, 32'h2000);
    @(posedge clock) rx_nonempty <= 1'b0;
    bus(32'h240, 1'b1, 3'h2, 32'h4000);
    #1 chk({31'h0, irq}, 32'h0);
    bus(32'h250, 1'b1, 3'h2, 32'h2000);
    rdchk(32'h248, 3'h2, 32'h0);
    rdchk(32'h208, 3'h2, 32'h0080);
    // Manual enqueue and reload of the TX pointer
    bus(32'h200, 1'b1, 3'h2, 32'h1);
    rdchk(32'h200, 3'h2, 32'h1);
    for (i = 0; i < 100 && irq !== 1'b1; i = i + 1) @(posedge clock);
    rdchk(32'h200, 3'h2, 32'h0);
    rdchk(32'h210, 3'h2, 32'h0123);
    rdchk(32'h248, 3'h2, 32'h4000);
    // Unmapped address
    bus(32'h3F0, 1'b1, 3'h2, 32'hFFFF);
    rdchk(32'h3F0, 3'h2, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    close_out;
  end
endmodule // tb
